// file: hdl/host_command_and_irq_logic.sv
// Host command interpreter, clock/power control and interrupt pin logic.
// Assumes register bits and event pulses arrive on the system clock.
`timescale 1ns/1ps
`default_nettype none
module host_command_and_irq_logic #(
  parameter logic [1:0] DEFAULT_STRENGTH = host_cmd_pkg::STRENGTH_5MA
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  input  wire logic [1:0]  spi_lanes,
  input  wire logic [7:0]  irq_src,
  input  wire logic        flags_rd,
  input  wire logic        int_en,
  input  wire logic [7:0]  int_mask,
  input  wire logic        int_push_pull,
  input  wire logic [7:0]  gpio_strength,
  input  wire logic [5:0]  query_group,
  output logic [7:0]       int_flags_q,
  output logic             int_n_o,
  output logic             int_n_oe,
  output logic             core_reset_q,
  output logic             sys_clk_en_q,
  output logic             osc_en_q,
  output logic             pll_en_q,
  output logic             core_power_q,
  output logic             power_down_q,
  output logic             pll_ext_sel_q,
  output logic [5:0]       pll_mult_q,
  output logic [1:0]       pll_range_q,
  output logic             cmd_done_q,
  output logic             cmd_dropped_q,
  output logic [1:0]       query_strength_q,
  output logic [1:0]       query_pd_state_q
);

  // ---- Link side ----
  logic [23:0] frame_bits;
  logic [4:0]  frame_count;

  spi_cmd_shift u_shift (
    .spi_sclk    (spi_sclk),
    .spi_cs_n    (spi_cs_n),
    .spi_mosi    (spi_mosi),
    .frame_bits  (frame_bits),
    .frame_count (frame_count)
  );

  // ---- End of frame detection ----
  logic [1:0] cs_sync_q;
  logic       cs_prev_q;
  logic       frame_end;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cs_sync_q <= 2'h3;
      cs_prev_q <= 1'b1;
    end else if (clk_en) begin
      cs_sync_q <= {cs_sync_q[0], spi_cs_n};
      cs_prev_q <= cs_sync_q[1];
    end
  end

  // Frame words are quasi-static: the serial clock is stopped while
  // chip select is high, so they are read only after its rise is synced.
  assign frame_end = clk_en & cs_sync_q[1] & ~cs_prev_q; // RL25

  logic [7:0] cmd_byte;
  logic [7:0] param;
  logic [7:0] tail;
  logic       well_formed;
  logic       lane_ok;
  logic       cmd_ok;

  assign cmd_byte = frame_bits[23:16];
  assign param    = frame_bits[15:8];
  assign tail     = frame_bits[7:0];

  assign well_formed = (frame_count == host_cmd_pkg::CMD_BITS)
    && (tail == 8'h00)
    && ((cmd_byte[7:6] == host_cmd_pkg::CMD_PREFIX)
        || (cmd_byte == host_cmd_pkg::CMD_ACTIVE && param == 8'h00)); // RL22

  assign lane_ok = (spi_lanes == host_cmd_pkg::LANES_SINGLE)
    || (cmd_byte == host_cmd_pkg::CMD_RST_PULSE); // RL23

  assign cmd_ok = frame_end && well_formed && lane_ok;

  // ---- Command decode ----
  logic do_active;
  logic do_standby;
  logic do_sleep;
  logic do_pwrdown;
  logic do_ext;
  logic do_int;
  logic do_mult;
  logic do_rst;
  logic do_strength;
  logic do_pd_state;
  logic known;

  always_comb begin
    do_active   = 1'b0;
    do_standby  = 1'b0;
    do_sleep    = 1'b0;
    do_pwrdown  = 1'b0;
    do_ext      = 1'b0;
    do_int      = 1'b0;
    do_mult     = 1'b0;
    do_rst      = 1'b0;
    do_strength = 1'b0;
    do_pd_state = 1'b0;
    known       = 1'b1;
    if (cmd_ok) begin
      case (cmd_byte)
        host_cmd_pkg::CMD_ACTIVE:       do_active   = 1'b1;
        host_cmd_pkg::CMD_STANDBY:      do_standby  = 1'b1;
        host_cmd_pkg::CMD_SLEEP:        do_sleep    = 1'b1;
        host_cmd_pkg::CMD_PWRDOWN,
        host_cmd_pkg::CMD_PWRDOWN_ALT:  do_pwrdown  = 1'b1;
        host_cmd_pkg::CMD_EXT_SOURCE:   do_ext      = 1'b1;
        host_cmd_pkg::CMD_INT_SOURCE:   do_int      = 1'b1;
        host_cmd_pkg::CMD_MULT,
        host_cmd_pkg::CMD_MULT_ALT:     do_mult     = 1'b1;
        host_cmd_pkg::CMD_RST_PULSE:    do_rst      = 1'b1;
        host_cmd_pkg::CMD_PIN_STRENGTH: do_strength = 1'b1;
        host_cmd_pkg::CMD_PD_PIN_STATE: do_pd_state = 1'b1;
        // Reserved codes are dropped; the host must not send them
        default:                        known       = 1'b0; // RL9
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cmd_done_q    <= 1'b0;
      cmd_dropped_q <= 1'b0;
    end else if (clk_en) begin
      cmd_done_q    <= cmd_ok & known;
      cmd_dropped_q <= frame_end & ~(cmd_ok & known);
    end
  end

  // ---- Power state ----
  host_cmd_pkg::power_state_t pwr_q;
  host_cmd_pkg::power_state_t pwr_d;

  always_comb begin
    pwr_d = pwr_q;
    if (do_active) begin
      pwr_d = host_cmd_pkg::PWR_ACTIVE; // RL16
    end else if (do_standby) begin
      pwr_d = host_cmd_pkg::PWR_STANDBY;
    end else if (do_sleep) begin
      pwr_d = host_cmd_pkg::PWR_SLEEP;
    end else if (do_pwrdown) begin
      pwr_d = host_cmd_pkg::PWR_DOWN;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      pwr_q <= host_cmd_pkg::PWR_SLEEP; // RL16
    end else if (clk_en) begin
      pwr_q <= pwr_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      sys_clk_en_q <= 1'b0;
      osc_en_q     <= 1'b0;
      pll_en_q     <= 1'b0;
      core_power_q <= 1'b1;
      power_down_q <= 1'b0;
    end else if (clk_en) begin
      sys_clk_en_q <= 1'b0;
      osc_en_q     <= 1'b0;
      pll_en_q     <= 1'b0;
      core_power_q <= 1'b1;
      power_down_q <= 1'b0;
      unique case (pwr_d)
        host_cmd_pkg::PWR_ACTIVE: begin
          sys_clk_en_q <= 1'b1; // RL16
          osc_en_q     <= 1'b1;
          pll_en_q     <= 1'b1;
        end
        host_cmd_pkg::PWR_STANDBY: begin
          osc_en_q <= 1'b1;
          pll_en_q <= 1'b1;
        end
        host_cmd_pkg::PWR_SLEEP: begin
        end
        host_cmd_pkg::PWR_DOWN: begin
          core_power_q <= 1'b0;
          power_down_q <= 1'b1; // RL6
        end
      endcase
    end
  end

  // ---- Clock source and multiplier ----
  logic [5:0] mult_field;
  logic       mult_legal;

  assign mult_field = param[5:0];
  assign mult_legal = (mult_field != host_cmd_pkg::MULT_RESERVED)
    && (mult_field <= host_cmd_pkg::MULT_MAX); // RL21

  // Power down drops the command-made clock setup; the reset pulse keeps it
  always_ff @(posedge clock) begin
    if (!rstn) begin
      pll_ext_sel_q <= 1'b0; // RL16
      pll_mult_q    <= host_cmd_pkg::DEFAULT_MULT; // RL18
      pll_range_q   <= host_cmd_pkg::DEFAULT_RANGE;
    end else if (clk_en) begin
      if (do_pwrdown) begin
        pll_ext_sel_q <= 1'b0;
        pll_mult_q    <= host_cmd_pkg::DEFAULT_MULT;
        pll_range_q   <= host_cmd_pkg::DEFAULT_RANGE;
      end else if (do_ext) begin
        pll_ext_sel_q <= 1'b1; // RL24
      end else if (do_int) begin
        pll_ext_sel_q <= 1'b0;
      end else if (do_mult && mult_legal
                   && pwr_q == host_cmd_pkg::PWR_SLEEP) begin // RL18
        if (mult_field == host_cmd_pkg::MULT_DEFAULT) begin
          pll_mult_q  <= host_cmd_pkg::DEFAULT_MULT; // RL21
          pll_range_q <= host_cmd_pkg::DEFAULT_RANGE;
        end else begin
          pll_mult_q  <= mult_field; // RL21
          pll_range_q <= param[7:6]; // RL20
        end
      end
    end
  end

  // ---- Core reset pulse ----
  localparam logic [3:0] RST_LEN = 4'(host_cmd_pkg::RST_PULSE_CYCLES);

  logic [3:0] rst_cnt_q;
  logic       rst_trigger;

  // Source switch resets only when the source really changes
  assign rst_trigger = do_rst
    | (do_ext & ~pll_ext_sel_q) // RL24
    | (do_int & pll_ext_sel_q);

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rst_cnt_q    <= '0;
      core_reset_q <= 1'b0;
    end else if (clk_en) begin
      if (rst_trigger) begin
        rst_cnt_q    <= RST_LEN;
        core_reset_q <= 1'b1; // RL1
      end else if (rst_cnt_q > 4'h1) begin
        rst_cnt_q <= rst_cnt_q - 4'h1;
      end else begin
        rst_cnt_q    <= '0;
        core_reset_q <= 1'b0;
      end
    end
  end

  // ---- Pin group settings ----
  logic [5:0] cmd_group;
  logic       cmd_group_ok;
  logic [5:0] rd_group;
  logic       rd_strength_set;
  logic [1:0] rd_strength;
  logic [1:0] rd_pd_state;

  assign cmd_group    = param[7:2]; // RL3 RL8
  assign cmd_group_ok = host_cmd_pkg::group_is_valid(cmd_group); // RL3

  // Shared pins follow the serial data group while in quad mode
  assign rd_group = (spi_lanes == host_cmd_pkg::LANES_QUAD
                     && query_group <= host_cmd_pkg::GRP_GPIO1)
    ? host_cmd_pkg::GRP_SERIAL : query_group; // RL5

  pin_setting_mem u_pins (
    .clock           (clock),
    .rstn            (rstn),
    .clk_en          (clk_en),
    .wr_strength     (do_strength & cmd_group_ok), // RL2
    .wr_pd_state     (do_pd_state & cmd_group_ok
                      & (param[1:0] != host_cmd_pkg::PD_RESERVED)), // RL7
    .clear_strength  (do_pwrdown),
    .wr_index        (host_cmd_pkg::group_index(cmd_group)),
    .wr_value        (param[1:0]),
    .rd_index        (host_cmd_pkg::group_index(rd_group)),
    .rd_strength_set (rd_strength_set),
    .rd_strength     (rd_strength),
    .rd_pd_state     (rd_pd_state)
  );

  logic       q_valid_q;
  logic       q_gpio_q;
  logic [1:0] q_gpio_bits_q;

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q_valid_q     <= 1'b0;
      q_gpio_q      <= 1'b0;
      q_gpio_bits_q <= '0;
    end else if (clk_en) begin
      q_valid_q     <= host_cmd_pkg::group_is_valid(rd_group);
      q_gpio_q      <= rd_group <= host_cmd_pkg::GRP_GPIO3;
      q_gpio_bits_q <= gpio_strength[{rd_group[1:0], 1'b0} +: 2];
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      query_strength_q <= DEFAULT_STRENGTH;
      query_pd_state_q <= host_cmd_pkg::PD_FLOAT;
    end else if (clk_en) begin
      if (q_valid_q && rd_strength_set) begin
        query_strength_q <= rd_strength; // RL4
      end else if (q_valid_q && q_gpio_q) begin
        query_strength_q <= q_gpio_bits_q; // RL4
      end else begin
        query_strength_q <= DEFAULT_STRENGTH;
      end
      if (q_valid_q && pwr_q == host_cmd_pkg::PWR_DOWN) begin
        query_pd_state_q <= rd_pd_state; // RL7
      end else begin
        query_pd_state_q <= host_cmd_pkg::PD_FLOAT;
      end
    end
  end

  // ---- Interrupts ----
  logic int_assert;

  // Bit 7 touch done, 6 queue flag, 5 queue empty, 4 playback end,
  // 3 sound end, 2 tag change, 1 touch, 0 list swap. Set beats clear.
  always_ff @(posedge clock) begin
    if (!rstn) begin
      int_flags_q <= '0;
    end else if (clk_en) begin
      int_flags_q <= (int_flags_q & ~{8{flags_rd}}) | irq_src; // RL13 RL15
    end
  end

  assign int_assert = int_en && |(int_flags_q & int_mask); // RL11 RL12

  always_ff @(posedge clock) begin
    if (!rstn) begin
      int_n_o  <= 1'b0;
      int_n_oe <= 1'b0;
    end else if (clk_en) begin
      if (int_push_pull) begin
        int_n_o  <= ~int_assert; // RL14
        int_n_oe <= int_en; // RL10
      end else begin
        int_n_o  <= 1'b0;
        int_n_oe <= int_assert; // RL10 RL11 RL14
      end
    end
  end

endmodule : host_command_and_irq_logic
`default_nettype wire

// file: include/host_cmd_pkg.sv
// Constants, state codes and helpers for the host command block.
// Assumes one system clock at 10 MHz and a serial host link clock.
// Summary of operation
// [RL1] Core reset pulse acts like power-on reset but keeps command settings.
// [RL2] Drive strength field: 0=5 mA, 1=10 mA, 2=15 mA, 3=20 mA.
// [RL3] Upper six parameter bits pick the pin group; unlisted groups ignored.
// [RL4] Strength comes from GPIO bits or a default until a command sets it.
// [RL5] In quad mode GPIO 0 and 1 use the serial data group strength.
// [RL6] While powered down, pins default to undriven.
// [RL7] Power-down pin state acts only in power down; state 3 is reserved.
// [RL8] Power-down pin state uses the same pin group coding as drive strength.
// [RL9] Host never sends undefined command codes.
// [RL10] Interrupt output disabled means the interrupt pin is not driven.
// [RL11] Interrupt enabled drives the pin low on any unmasked flag.
// [RL12] Mask bit one enables a source, zero disables it.
// [RL13] Sources set flags; reading the flag register clears them all.
// [RL14] Interrupt pin is open drain unless push-pull is selected.
// [RL15] Flag bits: 7 touch done down to 0 display list swap.
// [RL16] Power-on gives sleep, internal oscillator; active command starts clock.
// [RL17] Host selects external clock before the active command.
// [RL18] Default 60 MHz; multiplier command accepted only in sleep.
// [RL19] Host never trims the internal oscillator above 12 MHz.
// [RL20] Host sets range field to 1 for multipliers 4 and 5.
// [RL21] Multiplier 0 is default, 1 reserved, 2 to 5 multiply.
// [RL22] Command is prefix 01 plus code, parameter byte, then a zero byte.
// [RL23] Outside single lane mode only the reset pulse command is executed.
// [RL24] External clock command switches source and resets, unless already set.
// [RL25] Commands act only after 24 bits and chip select high.
// [RL26] Per-group strength and pin state are kept in unreadable storage.
package host_cmd_pkg;

  localparam int          CLOCK_MHZ        = 10;
  localparam int          RST_PULSE_NS     = 400;
  localparam int          RST_PULSE_CYCLES =
    (RST_PULSE_NS * CLOCK_MHZ + 999) / 1000;

  localparam logic [4:0]  CMD_BITS         = 5'h18;
  localparam logic [1:0]  CMD_PREFIX       = 2'h1;
  localparam logic [7:0]  CMD_ACTIVE       = 8'h00;
  localparam logic [7:0]  CMD_STANDBY      = 8'h41;
  localparam logic [7:0]  CMD_SLEEP        = 8'h42;
  localparam logic [7:0]  CMD_PWRDOWN      = 8'h43;
  localparam logic [7:0]  CMD_PWRDOWN_ALT  = 8'h50;
  localparam logic [7:0]  CMD_EXT_SOURCE   = 8'h44;
  localparam logic [7:0]  CMD_INT_SOURCE   = 8'h48;
  localparam logic [7:0]  CMD_MULT         = 8'h61;
  localparam logic [7:0]  CMD_MULT_ALT     = 8'h62;
  localparam logic [7:0]  CMD_RST_PULSE    = 8'h68;
  localparam logic [7:0]  CMD_PIN_STRENGTH = 8'h70;
  localparam logic [7:0]  CMD_PD_PIN_STATE = 8'h71;

  localparam logic [5:0]  GRP_GPIO3        = 6'h03;
  localparam logic [5:0]  GRP_PANEL        = 6'h08;
  localparam logic [5:0]  GRP_OFFSET       = 6'h04;
  localparam logic [5:0]  GRP_GPIO1        = 6'h01;
  localparam logic [5:0]  GRP_SERIAL       = 6'h13;
  localparam int          GRP_SLOTS        = 16;

  localparam logic [1:0]  STRENGTH_5MA     = 2'h0;
  localparam logic [1:0]  PD_FLOAT         = 2'h0;
  localparam logic [1:0]  PD_RESERVED      = 2'h3;

  localparam logic [5:0]  MULT_DEFAULT     = 6'h00;
  localparam logic [5:0]  MULT_RESERVED    = 6'h01;
  localparam logic [5:0]  MULT_MAX         = 6'h05;
  localparam logic [5:0]  DEFAULT_MULT     = 6'h05;
  localparam logic [1:0]  DEFAULT_RANGE    = 2'h1;

  localparam logic [1:0]  LANES_SINGLE     = 2'h0;
  localparam logic [1:0]  LANES_QUAD       = 2'h2;

  typedef enum logic [3:0] {
    PWR_SLEEP   = 4'h1,
    PWR_ACTIVE  = 4'h2,
    PWR_STANDBY = 4'h4,
    PWR_DOWN    = 4'h8
  } power_state_t;

  function automatic logic group_is_valid(input logic [5:0] g);
    return (g <= GRP_GPIO3) || (g >= GRP_PANEL && g <= GRP_SERIAL);
  endfunction : group_is_valid

  function automatic logic [3:0] group_index(input logic [5:0] g);
    logic [5:0] i;
    i = (g <= GRP_GPIO3) ? g : g - GRP_OFFSET;
    return i[3:0];
  endfunction : group_index

endpackage : host_cmd_pkg

// file: hdl/spi_cmd_shift.sv
// Link-side shifter for host command frames, clocked by the serial clock.
// Assumes serial mode 0: data sampled on the rising serial clock edge.
`timescale 1ns/1ps
`default_nettype none
module spi_cmd_shift (
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic [23:0]      frame_bits,
  output logic [4:0]       frame_count
);

  logic first_q;

  // Set by chip select itself since the serial clock stops between frames
  always_ff @(posedge spi_sclk or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge spi_sclk) begin
    if (!spi_cs_n) begin
      frame_bits <= {frame_bits[22:0], spi_mosi};
      if (first_q) begin
        frame_count <= 5'h01;
      end else if (frame_count <= host_cmd_pkg::CMD_BITS) begin
        frame_count <= frame_count + 5'h01; // RL25
      end
    end
  end

endmodule : spi_cmd_shift
`default_nettype wire

// file: hdl/pin_setting_mem.sv
// Per pin group store of drive strength and power-down pin state.
// Assumes writes and reads on the system clock; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module pin_setting_mem (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        wr_strength,
  input  wire logic        wr_pd_state,
  input  wire logic        clear_strength,
  input  wire logic [3:0]  wr_index,
  input  wire logic [1:0]  wr_value,
  input  wire logic [3:0]  rd_index,
  output logic             rd_strength_set,
  output logic [1:0]       rd_strength,
  output logic [1:0]       rd_pd_state
);

  localparam int N = host_cmd_pkg::GRP_SLOTS;

  logic [N-1:0] set_q;
  logic [1:0]   strength_q [N];
  logic [1:0]   pd_q       [N];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      set_q <= '0;
    end else if (clk_en) begin
      if (clear_strength) begin
        set_q <= '0;
      end else if (wr_strength) begin
        set_q[wr_index] <= 1'b1; // RL26
      end
    end
  end

  always_ff @(posedge clock) begin
    if (clk_en && wr_strength) begin
      strength_q[wr_index] <= wr_value; // RL26
    end
  end

  // Pin states survive everything but power-on reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      for (int i = 0; i < N; i++) begin
        pd_q[i] <= host_cmd_pkg::PD_FLOAT; // RL6
      end
    end else if (clk_en && wr_pd_state) begin
      pd_q[wr_index] <= wr_value; // RL26
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      rd_strength_set <= 1'b0;
      rd_strength     <= '0;
      rd_pd_state     <= host_cmd_pkg::PD_FLOAT;
    end else if (clk_en) begin
      rd_strength_set <= set_q[rd_index];
      rd_strength     <= strength_q[rd_index];
      rd_pd_state     <= pd_q[rd_index];
    end
  end

endmodule : pin_setting_mem
`default_nettype wire

// file: dv/host_cmd_chk.sv
// Checker for the host command block, bound to its top module.
// Assumes the bench holds clk_en high and keeps cs gaps of 680 ns, 6.8 clocks.
`timescale 1ns/1ps
`default_nettype none
module host_cmd_chk (
  input wire logic       clock,
  input wire logic       rstn,
  input wire logic       spi_cs_n,
  input wire logic [7:0] irq_src,
  input wire logic       flags_rd,
  input wire logic       int_en,
  input wire logic [7:0] int_mask,
  input wire logic       int_push_pull,
  input wire logic [7:0] int_flags_q,
  input wire logic       int_n_o,
  input wire logic       int_n_oe,
  input wire logic       core_reset_q,
  input wire logic       sys_clk_en_q,
  input wire logic       pll_en_q,
  input wire logic       power_down_q,
  input wire logic [5:0] pll_mult_q,
  input wire logic       cmd_done_q,
  input wire logic       cmd_dropped_q,
  input wire logic [1:0] query_pd_state_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_pulse4;
    core_reset_q [*4] ##1 !core_reset_q;
  endsequence
  a_od_level : assert property (
    $past(rstn) && !$past(int_push_pull) |-> !int_n_o && int_n_oe ==
    ($past(int_en) && |($past(int_flags_q) & $past(int_mask))))
    else $error("open drain level wrong");
  a_pp_level : assert property (
    $past(rstn) && $past(int_push_pull) |-> int_n_oe == $past(int_en)
    && int_n_o == !($past(int_en)
    && |($past(int_flags_q) & $past(int_mask))))
    else $error("push pull level wrong");
  a_irq_off : assert property (
    !$past(int_en) |-> !int_n_oe)
    else $error("interrupt pin driven while disabled");
  a_flag_set : assert property (
    |irq_src |=> (int_flags_q & $past(irq_src)) == $past(irq_src))
    else $error("flag not set by source");
  a_flag_clear : assert property (
    flags_rd && irq_src == 8'h00 |=> int_flags_q == 8'h00)
    else $error("flags not cleared by read");
  a_flag_hold : assert property (
    !flags_rd && irq_src == 8'h00 |=> $stable(int_flags_q))
    else $error("flags changed without cause");
  a_rst_pulse : assert property (
    $rose(core_reset_q) |-> cmd_done_q ##0 s_pulse4)
    else $error("core reset pulse wrong");
  a_mult_sleep : assert property (
    $past(rstn) && $changed(pll_mult_q) |-> cmd_done_q && !pll_en_q)
    else $error("multiplier changed outside sleep");
  a_clk_wake : assert property (
    $rose(sys_clk_en_q) |-> cmd_done_q)
    else $error("clock enabled without command");
  a_frame_end : assert property (
    cmd_done_q || cmd_dropped_q |-> spi_cs_n && $past(spi_cs_n, 2))
    else $error("command acted before chip select high");
  a_pd_float : assert property (
    !power_down_q [*4] |-> query_pd_state_q == host_cmd_pkg::PD_FLOAT)
    else $error("pin state shown outside power down");
endmodule : host_cmd_chk
bind host_command_and_irq_logic host_cmd_chk u_host_cmd_chk (
  .clock(clock), .rstn(rstn), .spi_cs_n(spi_cs_n), .irq_src(irq_src),
  .flags_rd(flags_rd), .int_en(int_en), .int_mask(int_mask),
  .int_push_pull(int_push_pull), .int_flags_q(int_flags_q),
  .int_n_o(int_n_o), .int_n_oe(int_n_oe), .core_reset_q(core_reset_q),
  .sys_clk_en_q(sys_clk_en_q), .pll_en_q(pll_en_q),
  .power_down_q(power_down_q), .pll_mult_q(pll_mult_q),
  .cmd_done_q(cmd_done_q), .cmd_dropped_q(cmd_dropped_q),
  .query_pd_state_q(query_pd_state_q));
`default_nettype wire

// file: dv/spi_host_model.sv
// Host link master model sending command frames in serial mode 0.
// Assumes the bench spaces frames; link clock period is 160 ns.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  initial begin
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    #1 spi_cs_n = 1'b1;
  end
  // Clock stands still between frames; data inverts once released
  task automatic send(input logic [23:0] f, input int n);
    #23 spi_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      spi_mosi = f[23 - i];
      #80 spi_sclk = 1'b1;
      #80 spi_sclk = 1'b0;
    end
    #80 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask : send
endmodule : spi_host_model
`default_nettype wire

// file: dv/tb_host_command_and_irq_logic.sv
// Self-checking bench for the host command block.
// Assumes the host model drives the link; clk_en is held high.
`timescale 1ns/1ps
`default_nettype none
module tb_host_command_and_irq_logic;
  logic       clock = 1'b0, rstn = 1'b0, flags_rd = 1'b0, int_en = 1'b0;
  logic       pp = 1'b0, rst_seen, spi_sclk, spi_cs_n, spi_mosi;
  logic       int_n_o, int_n_oe, core_reset_q, sys_clk_en_q;
  logic       power_down_q, ext_q, cmd_done_q, cmd_dropped_q;
  logic       osc_q, pll_q, cpw_q;
  logic [1:0] spi_lanes = 2'h0, range_q, qs, qp;
  logic [5:0] qg = 6'h00, mult_q;
  logic [7:0] irq_src = 8'h00, int_mask = 8'h00, gpio = 8'h00, flags;
  int         n_errors = 0, cmp_count = 0;
  always #50 clock = ~clock;
  spi_host_model u_spi_host_model (.spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));
  host_command_and_irq_logic u_host_command_and_irq_logic (
    .clock(clock), .rstn(rstn), .clk_en(1'b1), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_lanes(spi_lanes),
    .irq_src(irq_src), .flags_rd(flags_rd), .int_en(int_en),
    .int_mask(int_mask), .int_push_pull(pp), .gpio_strength(gpio),
    .query_group(qg), .int_flags_q(flags), .int_n_o(int_n_o),
    .int_n_oe(int_n_oe), .core_reset_q(core_reset_q),
    .sys_clk_en_q(sys_clk_en_q), .osc_en_q(osc_q), .pll_en_q(pll_q),
    .core_power_q(cpw_q), .power_down_q(power_down_q), .pll_ext_sel_q(ext_q),
    .pll_mult_q(mult_q), .pll_range_q(range_q), .cmd_done_q(cmd_done_q),
    .cmd_dropped_q(cmd_dropped_q), .query_strength_q(qs),
    .query_pd_state_q(qp));
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    #1 cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic finish_test();
    if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  // Poll catches the one-cycle answer pulse; then keep the cs gap
  task automatic cmd(input logic [23:0] f, input int n, input logic d);
    int k;
    u_spi_host_model.send(f, n);
    k = 0;
    while (cmd_done_q !== 1'b1 && cmd_dropped_q !== 1'b1 && k < 12) begin
      @(posedge clock);
      #1 k++;
    end
    if (cmd_done_q !== 1'b1 && cmd_dropped_q !== 1'b1) begin
      n_errors++;
      finish_test();
    end
    rst_seen = core_reset_q;
    chk({7'h0, cmd_dropped_q}, {7'h0, d});
    tick(4);
  endtask : cmd
  task automatic irq(input logic [7:0] v);
    tick(1);
    irq_src <= v;
    tick(1);
    irq_src <= 8'h00;
    tick(2);
  endtask : irq
  task automatic rd();
    tick(1);
    flags_rd <= 1'b1;
    tick(1);
    flags_rd <= 1'b0;
    tick(2);
  endtask : rd
  task automatic query(input logic [5:0] g);
    tick(1);
    qg <= g;
    tick(3);
  endtask : query
  initial begin
    tick(10);
    rstn <= 1'b1;
    tick(2);
    chk(flags, 8'h00);
    chk({7'h0, int_n_oe}, 8'h00);
    chk({7'h0, sys_clk_en_q}, 8'h00);
    chk({7'h0, ext_q}, 8'h00);
    chk({range_q, mult_q}, 8'h45);
    tick(1);
    int_en <= 1'b1;
    int_mask <= 8'hFF;
    for (int i = 0; i < 8; i++) begin
      irq(8'h01 << i);
      chk(flags, 8'h01 << i);
      chk({6'h0, int_n_oe, int_n_o}, 8'h02);
      rd();
      chk(flags, 8'h00);
    end
    tick(1);
    int_mask <= 8'h7E;
    irq(8'h81);
    chk({7'h0, int_n_oe}, 8'h00);
    tick(1);
    int_mask <= 8'hFF;
    tick(2);
    chk({7'h0, int_n_oe}, 8'h01);
    rd();
    pp <= 1'b1;
    irq(8'h02);
    chk({6'h0, int_n_oe, int_n_o}, 8'h02);
    rd();
    chk({6'h0, int_n_oe, int_n_o}, 8'h03);
    tick(1);
    int_en <= 1'b0;
    pp <= 1'b0;
    tick(2);
    chk({7'h0, int_n_oe}, 8'h00);
    cmd(24'h610300, 20, 1'b1);
    cmd(24'h610301, 24, 1'b1);
    cmd(24'h610300, 24, 1'b0);
    chk({range_q, mult_q}, 8'h03);
    cmd(24'h624400, 24, 1'b0);
    chk({range_q, mult_q}, 8'h44);
    cmd(24'h610100, 24, 1'b0);
    chk({range_q, mult_q}, 8'h44);
    cmd(24'h610000, 24, 1'b0);
    chk({range_q, mult_q}, 8'h45);
    cmd(24'h610200, 24, 1'b0);
    chk({range_q, mult_q}, 8'h02);
    cmd(24'h440000, 24, 1'b0);
    chk({6'h0, ext_q, rst_seen}, 8'h03);
    cmd(24'h440000, 24, 1'b0);
    chk({7'h0, rst_seen}, 8'h00);
    cmd(24'h000000, 24, 1'b0);
    chk({5'h0, osc_q, pll_q, sys_clk_en_q}, 8'h07);
    cmd(24'h614400, 24, 1'b0);
    chk({range_q, mult_q}, 8'h02);
    cmd(24'h680000, 24, 1'b0);
    chk({5'h0, rst_seen, ext_q, sys_clk_en_q}, 8'h07);
    chk({range_q, mult_q}, 8'h02);
    cmd(24'h410000, 24, 1'b0);
    chk({5'h0, osc_q, pll_q, sys_clk_en_q}, 8'h06);
    cmd(24'h480000, 24, 1'b0);
    chk({6'h0, ext_q, rst_seen}, 8'h01);
    tick(1);
    gpio <= 8'h31;
    query(6'h02);
    chk({6'h0, qs}, 8'h03);
    cmd(24'h700900, 24, 1'b0);
    query(6'h02);
    chk({6'h0, qs}, 8'h01);
    for (int s = 0; s < 4; s++) begin
      cmd({8'h70, 6'h08, 2'(s), 8'h00}, 24, 1'b0);
      query(6'h08);
      chk({6'h0, qs}, 8'(s));
    end
    cmd(24'h704E00, 24, 1'b0);
    query(6'h00);
    chk({6'h0, qs}, 8'h01);
    tick(1);
    spi_lanes <= 2'h2;
    query(6'h00);
    chk({6'h0, qs}, 8'h02);
    cmd(24'h700900, 24, 1'b1);
    cmd(24'h680000, 24, 1'b0);
    spi_lanes <= 2'h0;
    cmd(24'h430000, 24, 1'b0);
    query(6'h08);
    chk({4'h0, cpw_q, power_down_q, qs}, 8'h04);
    query(6'h09);
    chk({6'h0, qp}, 8'h00);
    cmd(24'h712900, 24, 1'b0);
    query(6'h0A);
    chk({6'h0, qp}, 8'h01);
    cmd(24'h712B00, 24, 1'b0);
    query(6'h0A);
    chk({6'h0, qp}, 8'h01);
    cmd(24'h000000, 24, 1'b0);
    query(6'h0A);
    chk({6'h0, qp}, 8'h00);
    cmd(24'h420000, 24, 1'b0);
    chk({5'h0, osc_q, pll_q, sys_clk_en_q}, 8'h00);
    finish_test();
  end
endmodule : tb_host_command_and_irq_logic
`default_nettype wire
